// ==== dv/testbench.sv ====
// self-checking bench of the timer control block: bus tasks, pin model, duty counts
// assumes: design and checker compiled before; clk at 250 MHz
`timescale 1ns/100ps
`include "tmw_defines.svh"
`default_nettype none
module testbench;
    localparam logic [5:0] CA = `TMW_IDX_CTRL_A, CB = `TMW_IDX_CTRL_B, CN = `TMW_IDX_COUNT,
        PA = `TMW_IDX_CMP_A, PB = `TMW_IDX_CMP_B, FL = `TMW_IDX_FLAGS;
    logic        clk = 1'b0;
    logic        rst_b = 1'b0;
    logic        hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0]  htrans = 2'h0;
    logic        hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0;
    logic        ext_clk_pin = 1'b0;
    logic        b_port = 1'b0;
    wire logic [31:0] hrdata;
    wire logic        hready;
    wire logic        b_wave, b_en, b_pin, a_wave, a_en;
    int          fail_count = 0;
    int          total_checks = 0;
    tmw_top u_dut (.clk(clk), .rst_b(rst_b), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(3'h2), .hready(hready), .hwdata(hwdata), .hrdata(hrdata),
        .hreadyout(hready), .hresp(), .ext_clk_pin(ext_clk_pin), .chan_a_wave_out(a_wave),
        .chan_a_out_en(a_en), .chan_b_wave_out(b_wave), .chan_b_out_en(b_en));
    tmw_pin_model u_pin (.wave(b_wave), .out_en(b_en), .dir_out(1'b1), .port_val(b_port),
        .pin(b_pin));
    initial forever #2 clk = ~clk;
    task automatic finish_test();
        $display("checks %0d mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        total_checks++;
        if (g !== e) begin
            fail_count++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic rdy();
        int n = 0;
        @(posedge clk);
        while (hready !== 1'b1) begin
            n++;
            if (n > 20) begin
                fail_count++;
                finish_test();
            end
            @(posedge clk);
        end
    endtask
    task automatic bus(input logic [5:0] i, input logic w, input logic [7:0] d,
                       output logic [31:0] q);
        hsel   <= 1'b1;
        haddr  <= {24'h0, i, 2'b00};
        htrans <= 2'b10;
        hwrite <= w;
        rdy();
        hsel   <= 1'b0;
        htrans <= 2'b00;
        hwdata <= {24'h0, d};
        rdy();
        q = hrdata;
    endtask
    task automatic wr(input logic [5:0] i, input logic [7:0] d);
        logic [31:0] q;
        bus(i, 1'b1, d, q);
    endtask
    task automatic rc(input string nm, input logic [5:0] i, input logic [31:0] e);
        logic [31:0] q;
        bus(i, 1'b0, 8'h00, q);
        chk(nm, e, q);
    endtask
    task automatic t_regs();
        rc("ctrl_a reset", CA, 32'h0);
        rc("ctrl_b reset", CB, 32'h0);
        wr(CB, 8'hf8);
        rc("ctrl_b bits", CB, 32'h08);
        wr(CA, 8'hff);
        rc("ctrl_a bits", CA, 32'hf3);
        rc("unmapped", 6'h3f, 32'h0);
        wr(CA, 8'h00);
        wr(CB, 8'h00);
    endtask
    task automatic t_force();
        logic [1:0] cm [4] = '{2'h1, 2'h2, 2'h3, 2'h1};
        logic       ex [4] = '{1'b1, 1'b0, 1'b1, 1'b0};
        for (int k = 0; k < 4; k++) begin
            wr(CA, {cm[k], cm[k], 4'h0});
            wr(CB, 8'hc0);
            repeat (2) @(posedge clk);
            chk("pin after force", ex[k], b_pin);
            chk("a after force", {1'b1, ex[k]}, {a_en, a_wave});
        end
        wr(CA, 8'h00);
        b_port <= 1'b1;
        repeat (2) @(posedge clk);
        chk("pin released", 1'b1, b_pin);
        b_port <= 1'b0;
        wr(CA, 8'h33);
        wr(CB, 8'h40);
        repeat (2) @(posedge clk);
        chk("pin pwm force", 1'b0, b_pin);
        wr(CA, 8'h02);
        wr(PA, 8'h05);
        wr(CN, 8'h20);
        wr(FL, 8'h07);
        wr(CB, 8'hc0);
        rc("count after force", CN, 32'h20);
        rc("flags after force", FL, 32'h0);
    endtask
    task automatic t_clk();
        logic [2:0]  cs [7] = '{3'h0, 3'h2, 3'h3, 3'h4, 3'h5, 3'h6, 3'h7};
        logic [7:0]  ex [7] = '{8'd0, 8'd129, 8'd16, 8'd4, 8'd1, 8'd5, 8'd5};
        logic [31:0] q;
        wr(CA, 8'h00);
        for (int k = 0; k < 7; k++) begin
            wr(CN, 8'h00);
            wr(CB, {5'h0, cs[k]});
            if (cs[k] > 3'h5)
                repeat (10) begin
                    repeat (8) @(posedge clk);
                    ext_clk_pin <= ~ext_clk_pin;
                end
            else
                repeat (1024) @(posedge clk);
            repeat (8) @(posedge clk);
            wr(CB, 8'h00);
            bus(CN, 1'b0, 8'h00, q);
            // prescaler phase is free-running, so one tick either way is allowed
            chk("count in range", 32'h1, 32'(q[7:0] - ex[k] + 8'h1 <= 8'h2));
        end
        wr(CN, 8'hfc);
        wr(FL, 8'h07);
        wr(CB, 8'h01);
        repeat (12) @(posedge clk);
        wr(CB, 8'h00);
        rc("flags normal", FL, 32'h7);
    endtask
    task automatic t_pwm();
        logic [7:0] ca [9] = '{8'h23, 8'h33, 8'h23, 8'h23, 8'h21, 8'h31, 8'h21, 8'h13, 8'h21};
        logic [7:0] cb [9] = '{8'h01, 8'h01, 8'h01, 8'h09, 8'h01, 8'h01, 8'h01, 8'h01, 8'h09};
        logic [7:0] pb [9] = '{8'h80, 8'h80, 8'hff, 8'h10, 8'h40, 8'h40, 8'hff, 8'h80, 8'h10};
        int         n  [9] = '{512, 512, 512, 512, 1020, 1020, 1020, 512, 504};
        int         ex [9] = '{258, 254, 512, 136, 256, 764, 1020, 0, 128};
        int         hi;
        wr(PA, 8'h3f);
        for (int k = 0; k < 9; k++) begin
            wr(CB, 8'h00);
            wr(PB, pb[k]);
            wr(CA, ca[k]);
            wr(CB, cb[k]);
            repeat (1100) @(posedge clk);
            hi = 0;
            repeat (n[k]) begin
                @(posedge clk);
                hi += (b_pin === 1'b1);
            end
            chk("high cycles", ex[k], hi);
        end
    endtask
    initial begin
        repeat (8) @(posedge clk);
        rst_b <= 1'b1;
        @(posedge clk);
        t_regs();
        t_force();
        t_clk();
        t_pwm();
        finish_test();
    end
endmodule
`default_nettype wire

// ==== dv/tmw_chk_sva.sv ====
// assertion checker for the timer control block, bound to its top
// assumes: one AHB-Lite master, zero wait states, control writes shadowed here
`timescale 1ns/100ps
`include "tmw_defines.svh"
`default_nettype none
module tmw_chk (
    input wire logic        clk,
    input wire logic        rst_b,
    input wire logic        hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0]  htrans,
    input wire logic        hwrite,
    input wire logic        hready,
    input wire logic [31:0] hwdata,
    input wire logic [31:0] hrdata,
    input wire logic        hreadyout,
    input wire logic        hresp,
    input wire logic        chan_b_wave_out,
    input wire logic        chan_b_out_en
);
    logic             dv_r;
    logic             dw_r;
    logic [31:0]      da_r;
    logic [7:0]       ca_r;
    logic [7:0]       cb_r;
    wire logic [31:0] adr_a = {24'h0, `TMW_IDX_CTRL_A, 2'b00};
    wire logic [31:0] adr_b = {24'h0, `TMW_IDX_CTRL_B, 2'b00};
    wire logic        wr_a  = dv_r && dw_r && da_r == adr_a;
    wire logic        wr_b  = dv_r && dw_r && da_r == adr_b;
    wire logic        rd_a  = dv_r && !dw_r && da_r == adr_a;
    wire logic        rd_b  = dv_r && !dw_r && da_r == adr_b;
    // force only judged with the counter stopped, so no tick can mask it
    wire logic        frc_b = wr_b && hwdata[6] && hwdata[2:0] == 3'h0 && cb_r[2:0] == 3'h0;
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            dv_r <= 1'b0;
            dw_r <= 1'b0;
            da_r <= 32'h0;
            ca_r <= 8'h00;
            cb_r <= 8'h00;
        end else begin
            dv_r <= hsel && htrans[1] && hready;
            dw_r <= hwrite;
            da_r <= haddr;
            if (wr_a)
                ca_r <= hwdata[7:0];
            if (wr_b)
                cb_r <= hwdata[7:0];
        end
    end
    default clocking dc @(posedge clk);
    endclocking
    default disable iff (!rst_b);
    a_bus_okay: assert property (hreadyout && !hresp && hrdata[31:8] == 24'h0)
        else $error("bus answer not okay");
    a_rsv_a_zero: assert property (rd_a |-> hrdata[3:2] == 2'h0)
        else $error("control a reserved bits not zero");
    a_rsv_b_zero: assert property (rd_b |-> hrdata[7:4] == 4'h0)
        else $error("control b force or reserved bits not zero");
    a_pin_on: assert property (wr_a && hwdata[5] && !(cb_r[3] && !hwdata[0]) |-> ##2 chan_b_out_en)
        else $error("channel b pin not taken over");
    a_pin_off: assert property (wr_a && (hwdata[5:4] == 2'h0 || (hwdata[5:4] == 2'h1 && hwdata[0])
            || (cb_r[3] && !hwdata[0])) |-> ##2 !chan_b_out_en)
        else $error("channel b pin not released");
    a_force_skip: assert property (frc_b && ca_r[0] |=> $stable(chan_b_wave_out) [*3])
        else $error("force acted in pwm mode");
    a_force_hit: assert property (frc_b && !ca_r[0] && !hwdata[3] && ca_r[5:4] != 2'h0 |-> ##2
            chan_b_wave_out == (ca_r[5:4] == 2'h1 ? !$past(chan_b_wave_out, 2) : ca_r[4]))
        else $error("force gave wrong channel b level");
    a_stop_hold: assert property (cb_r[2:0] == 3'h0 && $past(cb_r[2:0]) == 3'h0 && !wr_b
            && !$past(wr_b) |=> $stable(chan_b_wave_out))
        else $error("channel b moved with counter stopped");
endmodule
bind tmw_top tmw_chk u_chk (.clk(clk), .rst_b(rst_b), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hready(hready), .hwdata(hwdata), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .chan_b_wave_out(chan_b_wave_out),
    .chan_b_out_en(chan_b_out_en));
`default_nettype wire

// ==== dv/tmw_pin_model.sv ====
// far side of compare output b: port driver, direction bit and pull-up
// assumes: wave and enable come straight from the timer outputs
`timescale 1ns/100ps
`default_nettype none
module tmw_pin_model (
    input  wire logic wave,
    input  wire logic out_en,
    input  wire logic dir_out,
    input  wire logic port_val,
    output var  logic pin
);
    // waveform overrides port, driver needs direction
    always_comb begin
        if (!dir_out)
            pin = 1'b1;
        else if (out_en)
            pin = wave;
        else
            pin = port_val;
    end
endmodule
`default_nettype wire

// ==== rtl/tmw_defines.svh ====
// offsets, field positions, reset values and timing counts of the 8-bit timer control block
// assumes: included by its bare name from the design file, the checker and the bench
`ifndef TMW_DEFINES_SVH
`define TMW_DEFINES_SVH

// register indices; the byte address on the bus is four times the index
`define TMW_IDX_CTRL_A      6'h30
`define TMW_IDX_COUNT       6'h31
`define TMW_IDX_CTRL_B      6'h33
`define TMW_IDX_CMP_A       6'h34
`define TMW_IDX_CMP_B       6'h35
`define TMW_IDX_FLAGS       6'h36

// counter_control_a fields
`define TMW_A_COM_A_HI      7
`define TMW_A_COM_A_LO      6
`define TMW_A_COM_B_HI      5
`define TMW_A_COM_B_LO      4
`define TMW_A_WAVE_HI       1
`define TMW_A_WAVE_LO       0

// counter_control_b fields
`define TMW_B_FORCE_A       7
`define TMW_B_FORCE_B       6
`define TMW_B_WAVE_HIGH     3
`define TMW_B_CS_HI         2
`define TMW_B_CS_LO         0

// flag register fields
`define TMW_F_OVERFLOW      0
`define TMW_F_MATCH_A       1
`define TMW_F_MATCH_B       2

// reset values
`define TMW_RST_CTRL_A      8'h00
`define TMW_RST_CTRL_B      8'h00
`define TMW_RST_BYTE        8'h00

// counter extremes
`define TMW_MAX             8'hff
`define TMW_BOTTOM          8'h00

// waveform modes
`define TMW_WM_NORMAL       3'h0
`define TMW_WM_PC_FF        3'h1
`define TMW_WM_CTC          3'h2
`define TMW_WM_FAST_FF      3'h3
`define TMW_WM_RSV4         3'h4
`define TMW_WM_PC_A         3'h5
`define TMW_WM_RSV6         3'h6
`define TMW_WM_FAST_A       3'h7

// clock-select codes
`define TMW_CS_STOP         3'h0
`define TMW_CS_DIV1         3'h1
`define TMW_CS_DIV8         3'h2
`define TMW_CS_DIV64        3'h3
`define TMW_CS_DIV256       3'h4
`define TMW_CS_DIV1024      3'h5
`define TMW_CS_EXT_FALL     3'h6
`define TMW_CS_EXT_RISE     3'h7

// prescaler tap masks: a tick when all masked bits are one
`define TMW_PSC_MASK_8      10'h007
`define TMW_PSC_MASK_64     10'h03f
`define TMW_PSC_MASK_256    10'h0ff
`define TMW_PSC_MASK_1024   10'h3ff

`endif

// ==== rtl/tmw_pkg.sv ====
// types shared by the 8-bit timer control block
// assumes: nothing beyond the defines header
package tmw_pkg;

    // count sequence classes picked by the waveform mode
    typedef enum logic [1:0] {
        TMW_CLS_NORMAL,
        TMW_CLS_CTC,
        TMW_CLS_FAST,
        TMW_CLS_PHASE
    } tmw_cls_t;

    typedef logic [7:0] tmw_byte_t;

endpackage

// ==== rtl/tmw_top.sv ====
// 8-bit timer/counter with waveform modes, compare outputs and force strobes
// assumes: one AHB-Lite master, ext_clk_pin asynchronous to clk, port logic outside
// Contract
// R1 - nonzero B mode overrides pin port function; code leaves B pin off for code 01 in PWM modes
// R2 - software sets B pin direction to output
// R3 - non-PWM B: off, toggle, clear, set
// R4 - fast PWM B: clear/set match, reverse at BOTTOM
// R5 - fast B: compare equal TOP acts at BOTTOM
// R6 - phase PWM B: up/down match opposite actions
// R7 - phase B: compare equal TOP acts at TOP
// R8 - reserved control bits read as zero
// R9 - wave mode from B high, A low bits
// R10 - modes 0,2: immediate update, overflow MAX
// R11 - modes 1,5: load at TOP, overflow BOTTOM
// R12 - modes 3,7: load BOTTOM; 4,6 reserved
// R13 - MAX is 0xFF, BOTTOM is 0x00
// R14 - force bits act only in non-PWM modes
// R15 - software writes zero force bits in PWM
// R16 - force applies immediate match per mode
// R17 - force sets no flag, no counter clear
// R18 - force bits always read as zero
// R19 - control B resets zero, mixed access
// R20 - clock select: stop, divided, external edges
// R21 - reserved codes: pins off, normal counting
// R22 - PWM compare values double buffered
`timescale 1ns/100ps
`include "tmw_defines.svh"
`default_nettype none

module tmw_top #(
    parameter int PSC_W = 10
) (
    input  wire logic        clk,
    input  wire logic        rst_b,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic        hready,
    input  wire logic [31:0] hwdata,
    output var  logic [31:0] hrdata,
    output var  logic        hreadyout,
    output var  logic        hresp,
    input  wire logic        ext_clk_pin,
    output var  logic        chan_a_wave_out,
    output var  logic        chan_a_out_en,
    output var  logic        chan_b_wave_out,
    output var  logic        chan_b_out_en
);

    // tick when every masked prescaler bit is one
    function automatic logic presc_hit(input logic [PSC_W-1:0] cnt,
                                       input logic [PSC_W-1:0] mask);
        presc_hit = &(cnt | ~mask);
    endfunction

    // next level of one compare output
    function automatic logic wave_next(input logic              cur,
                                       input logic [1:0]        com,
                                       input tmw_pkg::tmw_cls_t cls,
                                       input logic              hit,
                                       input logic              wrap,
                                       input logic              peak,
                                       input logic              down,
                                       input logic              eq_top,
                                       input logic              tog_pwm);
        logic nv;
        nv = cur;
        case (cls)
            tmw_pkg::TMW_CLS_FAST: begin
                if (com[1]) begin
                    // R4 set or clear at bottom
                    if (wrap)
                        nv = ~com[0];
                    // R5 match ignored at top
                    else if (hit && !eq_top)
                        nv = com[0];
                end else if (com[0] && tog_pwm && hit) begin
                    nv = ~cur;
                end
            end
            tmw_pkg::TMW_CLS_PHASE: begin
                if (com[1]) begin
                    // R7 acts at top instead
                    if (eq_top) begin
                        if (peak)
                            nv = ~com[0];
                    // R6 direction picks action
                    end else if (hit) begin
                        nv = com[0] ^ down;
                    end
                end else if (com[0] && tog_pwm && hit) begin
                    nv = ~cur;
                end
            end
            default: begin
                // R3 toggle clear set
                if (hit) begin
                    case (com)
                        2'b01:   nv = ~cur;
                        2'b10:   nv = 1'b0;
                        2'b11:   nv = 1'b1;
                        default: nv = cur;
                    endcase
                end
            end
        endcase
        wave_next = nv;
    endfunction

    // bus state
    logic              wr_pend_r;
    logic [5:0]        wr_idx_r;
    logic [31:0]       hrdata_r;
    logic              hreadyout_r;
    logic              hresp_r;

    // control and data state
    logic [1:0]        com_a_r;
    logic [1:0]        com_b_r;
    logic [1:0]        wave_low_r;
    logic              wave_high_r;
    logic [2:0]        clk_sel_r;
    logic [7:0]        cnt_r;
    logic [7:0]        cnt_nxt;
    logic              down_r;
    logic              down_nxt;
    logic              blk_r;
    logic [7:0]        cmp_a_buf_r;
    logic [7:0]        cmp_b_buf_r;
    logic [7:0]        cmp_a_act_r;
    logic [7:0]        cmp_b_act_r;
    logic [2:0]        flags_r;
    logic              force_a_r;
    logic              force_b_r;
    logic [PSC_W-1:0]  psc_r;

    // external clock pin synchroniser and filtered level
    logic              ext_s1_r;
    logic              ext_s2_r;
    logic              ext_s3_r;
    logic              ext_lvl_r;

    // output flops
    logic              wave_a_r;
    logic              wave_b_r;
    logic              en_a_r;
    logic              en_b_r;

    // address phase decode
    wire               ap_valid = hsel && htrans[1] && hready;
    wire               ap_map   = (haddr[31:8] == 24'h0) && (haddr[1:0] == 2'b00);
    wire [5:0]         ap_idx   = haddr[7:2];

    // data phase write strobes
    wire               wr_ctrl_a = wr_pend_r && (wr_idx_r == `TMW_IDX_CTRL_A);
    wire               wr_ctrl_b = wr_pend_r && (wr_idx_r == `TMW_IDX_CTRL_B);
    wire               wr_count  = wr_pend_r && (wr_idx_r == `TMW_IDX_COUNT);
    wire               wr_cmp_a  = wr_pend_r && (wr_idx_r == `TMW_IDX_CMP_A);
    wire               wr_cmp_b  = wr_pend_r && (wr_idx_r == `TMW_IDX_CMP_B);
    wire               wr_flags  = wr_pend_r && (wr_idx_r == `TMW_IDX_FLAGS);

    // R9 three-bit mode
    wire [2:0]         wave_mode_sel = {wave_high_r, wave_low_r};
    // R21 reserved modes count as normal
    wire               rsv_mode = (wave_mode_sel == `TMW_WM_RSV4)
                               || (wave_mode_sel == `TMW_WM_RSV6);

    // R12 mode to class
    wire tmw_pkg::tmw_cls_t cls =
        (wave_mode_sel == `TMW_WM_CTC) ? tmw_pkg::TMW_CLS_CTC :
        ((wave_mode_sel == `TMW_WM_PC_FF) || (wave_mode_sel == `TMW_WM_PC_A))
            ? tmw_pkg::TMW_CLS_PHASE :
        ((wave_mode_sel == `TMW_WM_FAST_FF) || (wave_mode_sel == `TMW_WM_FAST_A))
            ? tmw_pkg::TMW_CLS_FAST : tmw_pkg::TMW_CLS_NORMAL;
    wire               pwm = (cls == tmw_pkg::TMW_CLS_FAST)
                          || (cls == tmw_pkg::TMW_CLS_PHASE);

    // R10 top source per mode
    wire               top_is_a = (wave_mode_sel == `TMW_WM_CTC)
                               || (wave_mode_sel == `TMW_WM_PC_A)
                               || (wave_mode_sel == `TMW_WM_FAST_A);
    // R13 fixed extremes
    wire [7:0]         top = top_is_a ? cmp_a_act_r : `TMW_MAX;

    // R20 clock source decode
    wire               ext_stable = (ext_s2_r == ext_s3_r);
    wire               ext_rise   = ext_stable && ext_s3_r && !ext_lvl_r;
    wire               ext_fall   = ext_stable && !ext_s3_r && ext_lvl_r;
    wire               tick =
        (clk_sel_r == `TMW_CS_DIV1)     ? 1'b1 :
        (clk_sel_r == `TMW_CS_DIV8)     ? presc_hit(psc_r, `TMW_PSC_MASK_8) :
        (clk_sel_r == `TMW_CS_DIV64)    ? presc_hit(psc_r, `TMW_PSC_MASK_64) :
        (clk_sel_r == `TMW_CS_DIV256)   ? presc_hit(psc_r, `TMW_PSC_MASK_256) :
        (clk_sel_r == `TMW_CS_DIV1024)  ? presc_hit(psc_r, `TMW_PSC_MASK_1024) :
        (clk_sel_r == `TMW_CS_EXT_FALL) ? ext_fall :
        (clk_sel_r == `TMW_CS_EXT_RISE) ? ext_rise : 1'b0;

    // counting events
    wire               at_top  = (cnt_r == top);
    wire               at_bot  = (cnt_r == `TMW_BOTTOM);
    wire               is_phase = (cls == tmw_pkg::TMW_CLS_PHASE);
    wire               wrap    = tick && !is_phase && at_top;
    wire               peak    = tick && is_phase && !down_r && at_top;
    wire               valley  = tick && is_phase && down_r && at_bot;
    // a counter write blocks the match on the following tick
    wire               hit_a   = tick && !blk_r && (cnt_r == cmp_a_act_r);
    wire               hit_b   = tick && !blk_r && (cnt_r == cmp_b_act_r);

    // R10 overflow at max in 0,2,3
    // R11 overflow at bottom in phase modes
    // R12 overflow at top in mode 7
    wire               ovf_evt =
        is_phase ? valley :
        (wave_mode_sel == `TMW_WM_FAST_A) ? (tick && at_top) :
        (tick && (cnt_r == `TMW_MAX));

    // R22 compare update point
    wire               upd_cmp =
        (cls == tmw_pkg::TMW_CLS_FAST)  ? wrap :
        (cls == tmw_pkg::TMW_CLS_PHASE) ? peak : 1'b1;

    // R14 force only outside pwm
    wire               force_a_set = wr_ctrl_b && hwdata[`TMW_B_FORCE_A] && !pwm;
    wire               force_b_set = wr_ctrl_b && hwdata[`TMW_B_FORCE_B] && !pwm;

    // R17 force excluded from flags
    wire [2:0]         flag_set = {hit_b, hit_a, ovf_evt};
    wire [2:0]         flag_clr = wr_flags ? hwdata[2:0] : 3'b000;

    // R16 forced match drives the wave unit
    wire               wave_a_nxt = wave_next(wave_a_r, com_a_r, cls, hit_a || force_a_r,
                                              wrap, peak, down_r,
                                              cmp_a_act_r == top, wave_high_r);
    // R15 force ignored under pwm
    wire               wave_b_nxt = wave_next(wave_b_r, com_b_r, cls, hit_b || force_b_r,
                                              wrap, peak, down_r,
                                              cmp_b_act_r == top, 1'b0);

    // R1 pin override when mode nonzero, except code 01 under pwm (for a, only while wave_high_r is clear)
    // R21 reserved codes leave pin off
    wire               en_b_nxt = (com_b_r != 2'b00) && !rsv_mode
                               && !(pwm && (com_b_r == 2'b01));
    wire               en_a_nxt = (com_a_r != 2'b00) && !rsv_mode
                               && !(pwm && (com_a_r == 2'b01) && !wave_high_r);

    // R8 reserved bits zero
    // R18 force bits read zero
    wire [7:0]         ctrl_a_rd = {com_a_r, com_b_r, 2'b00, wave_low_r};
    wire [7:0]         ctrl_b_rd = {4'h0, wave_high_r, clk_sel_r};
    wire [7:0]         rd_byte =
        !ap_map                        ? 8'h00 :
        (ap_idx == `TMW_IDX_CTRL_A)    ? ctrl_a_rd :
        (ap_idx == `TMW_IDX_CTRL_B)    ? ctrl_b_rd :
        (ap_idx == `TMW_IDX_COUNT)     ? cnt_r :
        (ap_idx == `TMW_IDX_CMP_A)     ? cmp_a_buf_r :
        (ap_idx == `TMW_IDX_CMP_B)     ? cmp_b_buf_r :
        (ap_idx == `TMW_IDX_FLAGS)     ? {5'h00, flags_r} : 8'h00;

    // counter and direction
    always_comb begin
        cnt_nxt  = cnt_r;
        down_nxt = is_phase ? down_r : 1'b0;
        if (wr_count) begin
            cnt_nxt = hwdata[7:0];
        end else if (tick) begin
            if (is_phase) begin
                if (!down_r && at_top) begin
                    down_nxt = 1'b1;
                    cnt_nxt  = at_bot ? cnt_r : cnt_r - 8'h01;
                end else if (down_r && at_bot) begin
                    down_nxt = 1'b0;
                    cnt_nxt  = at_top ? cnt_r : cnt_r + 8'h01;
                end else begin
                    cnt_nxt  = down_r ? cnt_r - 8'h01 : cnt_r + 8'h01;
                end
            end else if (at_top) begin
                cnt_nxt = `TMW_BOTTOM;
            end else begin
                cnt_nxt = cnt_r + 8'h01;
            end
        end
    end

    // bus slave: zero wait, read data registered in the address phase
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            wr_pend_r   <= 1'b0;
            wr_idx_r    <= 6'h00;
            hrdata_r    <= 32'h0000_0000;
            hreadyout_r <= 1'b1;
            hresp_r     <= 1'b0;
        end else begin
            wr_pend_r   <= ap_valid && hwrite && ap_map;
            wr_idx_r    <= ap_idx;
            hreadyout_r <= 1'b1;
            hresp_r     <= 1'b0;
            if (ap_valid && !hwrite)
                hrdata_r <= {24'h00_0000, rd_byte};
        end
    end

    // R19 control registers reset to zero
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            com_a_r     <= 2'(`TMW_RST_CTRL_A >> `TMW_A_COM_A_LO);
            com_b_r     <= 2'b00;
            wave_low_r  <= 2'b00;
            wave_high_r <= 1'(`TMW_RST_CTRL_B >> `TMW_B_WAVE_HIGH);
            clk_sel_r   <= `TMW_CS_STOP;
            force_a_r   <= 1'b0;
            force_b_r   <= 1'b0;
        end else begin
            if (wr_ctrl_a) begin
                com_a_r    <= hwdata[`TMW_A_COM_A_HI:`TMW_A_COM_A_LO];
                com_b_r    <= hwdata[`TMW_A_COM_B_HI:`TMW_A_COM_B_LO];
                wave_low_r <= hwdata[`TMW_A_WAVE_HI:`TMW_A_WAVE_LO];
            end
            if (wr_ctrl_b) begin
                wave_high_r <= hwdata[`TMW_B_WAVE_HIGH];
                clk_sel_r   <= hwdata[`TMW_B_CS_HI:`TMW_B_CS_LO];
            end
            // one-cycle strobes, never stored
            force_a_r <= force_a_set;
            force_b_r <= force_b_set;
        end
    end

    // counter, prescaler, compare buffers, flags
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            cnt_r       <= `TMW_RST_BYTE;
            down_r      <= 1'b0;
            blk_r       <= 1'b0;
            psc_r       <= '0;
            cmp_a_buf_r <= `TMW_RST_BYTE;
            cmp_b_buf_r <= `TMW_RST_BYTE;
            cmp_a_act_r <= `TMW_RST_BYTE;
            cmp_b_act_r <= `TMW_RST_BYTE;
            flags_r     <= 3'b000;
        end else begin
            cnt_r  <= cnt_nxt;
            down_r <= down_nxt;
            blk_r  <= wr_count || (blk_r && !tick);
            // shared prescaler keeps running so divided taps stay in phase
            psc_r  <= psc_r + 1'b1;
            if (wr_cmp_a)
                cmp_a_buf_r <= hwdata[7:0];
            if (wr_cmp_b)
                cmp_b_buf_r <= hwdata[7:0];
            // R22 copy at the update point
            if (upd_cmp) begin
                cmp_a_act_r <= cmp_a_buf_r;
                cmp_b_act_r <= cmp_b_buf_r;
            end
            // set wins over a clear in the same cycle
            flags_r <= (flags_r & ~flag_clr) | flag_set;
        end
    end

    // external pin: change counts once second and third stage agree
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            ext_s1_r  <= 1'b0;
            ext_s2_r  <= 1'b0;
            ext_s3_r  <= 1'b0;
            ext_lvl_r <= 1'b0;
        end else begin
            ext_s1_r <= ext_clk_pin;
            ext_s2_r <= ext_s1_r;
            ext_s3_r <= ext_s2_r;
            if (ext_stable)
                ext_lvl_r <= ext_s3_r;
        end
    end

    // compare outputs and pin enables
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            wave_a_r <= 1'b0;
            wave_b_r <= 1'b0;
            en_a_r   <= 1'b0;
            en_b_r   <= 1'b0;
        end else begin
            wave_a_r <= wave_a_nxt;
            wave_b_r <= wave_b_nxt;
            en_a_r   <= en_a_nxt;
            en_b_r   <= en_b_nxt;
        end
    end

    assign hrdata          = hrdata_r;
    assign hreadyout       = hreadyout_r;
    assign hresp           = hresp_r;
    assign chan_a_wave_out = wave_a_r;
    assign chan_a_out_en   = en_a_r;
    assign chan_b_wave_out = wave_b_r;
    assign chan_b_out_en   = en_b_r;

endmodule

`default_nettype wire
